// >>> src/sfil_top.sv
// Interrupt logic, watermark and full detection, flush and over-read of the sensor FIFO.
//
// How it works
// - On over-read send one sensortime frame if enabled, then empty frames.
// - Flush or soft reset command code empties the FIFO.
// - All routed interrupt contributions are ORed onto one pin.
// - After reset or soft reset the pin is push-pull, active high.
// - Non-latched pin follows live conditions and drops when none holds.
// - Non-latched data ready drops on status read or 2.5 ms after assertion.
// - FIFO data reads do not touch watermark or full pin contributions.
// - Latched mode drives the pin from stored watermark and full status bits.
// - Every pin assertion lasts at least one microsecond.
// - Status bits are always readable and ignore pin configuration.
// - Drive-type bit: 0 push-pull, 1 open-drain.
// - Polarity bit: 0 active low, 1 active high.
// - Latch bit 1 latches pin and watermark and full status, 0 does not; data-ready status is held until read either way.
// - Watermark and full reach the pin only when their enables are set.
// - Watermark holds when fill length reaches it; zero never holds.
// - Watermark is re-evaluated at the end of a transaction that wrote it.
// - Full condition is 504 or more unread bytes; it sets full status.
// - Reading full status clears it only below 504 bytes.
// - Data-ready status sets when a measurement has been stored.
// - Data ready reaches pin only when enabled; reading its status clears it.
// - Self-clear timer starts only at a data-ready event in non-latched mode.
// - Enabling data-ready routing late keeps its contribution 0 until next event.
// - Empty frame is a sensor header with no enables plus one zero byte.
`timescale 1ns/1ps
module sfil_top #(
  parameter int unsigned DRDY_CLR_CYC = sfil_pkg::DRDY_CLR_CYC_DEF
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic xfer_end_in,
  input wire logic drdy_event_in,
  input wire logic [15:0] fifo_length_in,
  input wire logic fifo_empty_in,
  input wire logic [7:0] fifo_byte_in,
  input wire logic time_en_in,
  input wire logic [23:0] sensor_time_in,
  output logic [7:0] reg_rdata_out,
  output logic fifo_pop_out,
  output logic fifo_flush_out,
  output logic int_out,
  output logic int_oe_out
);

  localparam logic [15:0] CLR_LAST = 16'(DRDY_CLR_CYC - 1);
  localparam logic [4:0] HOLD_INIT = 5'(sfil_pkg::MIN_PULSE_CYC - 1);

  sfil_pkg::sfil_ctrl_t ctrl_q, ctrl_d;
  sfil_pkg::sfil_stat_t stat_q, stat_d;
  logic [7:0] wtm_lo_q, wtm_lo_d, wtm_hi_q, wtm_hi_d;
  logic [15:0] wtm_eff_q, wtm_eff_d;
  logic wtm_dirty_q, wtm_dirty_d;
  logic drdy_pin_q, drdy_pin_d;
  logic tmr_run_q, tmr_run_d;
  logic [15:0] tmr_q, tmr_d;
  logic [7:0] rdata_q, rdata_d;
  logic pop_q, flush_q, flush_d;
  logic active_q, active_d;
  logic [4:0] hold_q, hold_d;
  logic int_q, int_d, oe_q, oe_d;

  logic wtm_cond, full_cond, rd_stat, data_rd, cmd_wr, srst, contrib, want_level;
  logic [7:0] ovr_byte;
  logic ovr_pop;

  // Watermark uses the value committed at transaction end, so a half-written pair is not seen.
  assign wtm_cond = (wtm_eff_q != sfil_pkg::WTM_RST) && (fifo_length_in >= wtm_eff_q);
  assign full_cond = fifo_length_in >= sfil_pkg::FULL_LEVEL;
  assign rd_stat = reg_rd_in && (reg_addr_in == sfil_pkg::ADDR_INT_STATUS);
  assign data_rd = reg_rd_in && (reg_addr_in == sfil_pkg::ADDR_FIFO_DATA);
  assign cmd_wr = reg_wr_in && (reg_addr_in == sfil_pkg::ADDR_CMD);
  assign srst = cmd_wr && (reg_wdata_in == sfil_pkg::CMD_SOFT_RESET);

  sfil_overread u_overread (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .data_rd_in(data_rd),
    .burst_end_in(xfer_end_in),
    .fifo_empty_in(fifo_empty_in),
    .fifo_byte_in(fifo_byte_in),
    .time_en_in(time_en_in),
    .sensor_time_in(sensor_time_in),
    .byte_out(ovr_byte),
    .pop_out(ovr_pop)
  );

  // Pin contributions; FIFO data reads appear nowhere here.
  always_comb begin
    if (ctrl_q.latch) begin
      contrib = (stat_q.fwm & ctrl_q.fwtm_en) | (stat_q.ffull & ctrl_q.ffull_en) | drdy_pin_q;
    end else begin
      contrib = (wtm_cond & ctrl_q.fwtm_en) | (full_cond & ctrl_q.ffull_en) | drdy_pin_q;
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    wtm_lo_d = wtm_lo_q;
    wtm_hi_d = wtm_hi_q;
    wtm_eff_d = wtm_eff_q;
    wtm_dirty_d = wtm_dirty_q;
    drdy_pin_d = drdy_pin_q;
    tmr_run_d = tmr_run_q;
    tmr_d = tmr_q;
    rdata_d = rdata_q;
    flush_d = 1'b0;
    // Status: clears first, sets last so a coinciding event wins.
    if (rd_stat && stat_q.drdy) begin
      stat_d.drdy = 1'b0;
    end
    if (rd_stat && stat_q.ffull && !full_cond) begin
      stat_d.ffull = 1'b0;
    end
    if (rd_stat) begin
      stat_d.fwm = 1'b0;
    end
    if (ctrl_q.latch) begin
      stat_d.fwm = stat_d.fwm | wtm_cond;
      stat_d.ffull = stat_d.ffull | full_cond;
    end else begin
      stat_d.fwm = wtm_cond;
      stat_d.ffull = full_cond;
    end
    if (drdy_event_in) begin
      stat_d.drdy = 1'b1;
    end
    // Data-ready pin contribution and its self-clear timer.
    if (drdy_event_in) begin
      drdy_pin_d = ctrl_q.drdy_en;
      tmr_run_d = !ctrl_q.latch;
      tmr_d = 16'h0000;
    end else if (rd_stat) begin
      drdy_pin_d = 1'b0;
      tmr_run_d = 1'b0;
    end else if (tmr_run_q) begin
      if (tmr_q == CLR_LAST) begin
        drdy_pin_d = 1'b0;
        tmr_run_d = 1'b0;
      end else begin
        tmr_d = tmr_q + 16'h0001;
      end
    end
    // Register writes.
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        sfil_pkg::ADDR_WTM_LO: begin
          wtm_lo_d = reg_wdata_in;
          wtm_dirty_d = 1'b1;
        end
        sfil_pkg::ADDR_WTM_HI: begin
          wtm_hi_d = reg_wdata_in;
          wtm_dirty_d = 1'b1;
        end
        sfil_pkg::ADDR_INT_CTRL: begin
          ctrl_d = reg_wdata_in & sfil_pkg::CTRL_WR_MASK;
        end
        sfil_pkg::ADDR_CMD: begin
          if (reg_wdata_in == sfil_pkg::CMD_FIFO_FLUSH || srst) begin
            flush_d = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // A byte written in the closing cycle is committed with the pair instead of being lost.
    if (xfer_end_in && wtm_dirty_d) begin
      wtm_eff_d = {wtm_hi_d, wtm_lo_d};
      wtm_dirty_d = 1'b0;
    end
    // Register reads; unmapped and write-only addresses read zero.
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        sfil_pkg::ADDR_INT_STATUS: rdata_d = stat_q;
        sfil_pkg::ADDR_FIFO_LEN_LO: rdata_d = fifo_length_in[7:0];
        sfil_pkg::ADDR_FIFO_LEN_HI: rdata_d = fifo_length_in[15:8];
        sfil_pkg::ADDR_FIFO_DATA: rdata_d = ovr_byte;
        sfil_pkg::ADDR_WTM_LO: rdata_d = wtm_lo_q;
        sfil_pkg::ADDR_WTM_HI: rdata_d = wtm_hi_q;
        sfil_pkg::ADDR_INT_CTRL: rdata_d = ctrl_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // Soft reset restores every setting; the FIFO is flushed above.
    if (srst) begin
      ctrl_d = sfil_pkg::CTRL_RST;
      stat_d = sfil_pkg::STAT_RST;
      wtm_lo_d = 8'h00;
      wtm_hi_d = 8'h00;
      wtm_eff_d = sfil_pkg::WTM_RST;
      wtm_dirty_d = 1'b0;
      drdy_pin_d = 1'b0;
      tmr_run_d = 1'b0;
      tmr_d = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= sfil_pkg::CTRL_RST;
      stat_q <= sfil_pkg::STAT_RST;
      wtm_lo_q <= 8'h00;
      wtm_hi_q <= 8'h00;
      wtm_eff_q <= sfil_pkg::WTM_RST;
      wtm_dirty_q <= 1'b0;
      drdy_pin_q <= 1'b0;
      tmr_run_q <= 1'b0;
      tmr_q <= 16'h0000;
      rdata_q <= 8'h00;
      pop_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      wtm_lo_q <= wtm_lo_d;
      wtm_hi_q <= wtm_hi_d;
      wtm_eff_q <= wtm_eff_d;
      wtm_dirty_q <= wtm_dirty_d;
      drdy_pin_q <= drdy_pin_d;
      tmr_run_q <= tmr_run_d;
      tmr_q <= tmr_d;
      rdata_q <= rdata_d;
      pop_q <= ovr_pop;
      flush_q <= flush_d;
    end
  end

  // Output stage: one pulse stretcher, then polarity and drive for all sources.
  always_comb begin
    active_d = active_q;
    hold_d = hold_q;
    if (!active_q) begin
      if (contrib) begin
        active_d = 1'b1;
        hold_d = HOLD_INIT;
      end
    end else if (hold_q != 5'h00) begin
      hold_d = hold_q - 5'h01;
    end else if (!contrib) begin
      active_d = 1'b0;
    end
    want_level = ctrl_q.level ~^ active_q;
    if (ctrl_q.pin_drive_type) begin
      // Open drain can only pull low; the high level comes from the board.
      int_d = 1'b0;
      oe_d = !want_level;
    end else begin
      int_d = want_level;
      oe_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active_q <= 1'b0;
      hold_q <= 5'h00;
      int_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      active_q <= active_d;
      hold_q <= hold_d;
      int_q <= int_d;
      oe_q <= oe_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign fifo_pop_out = pop_q;
  assign fifo_flush_out = flush_q;
  assign int_out = int_q;
  assign int_oe_out = oe_q;

  // Length of the current pin assertion, read only by the width check.
  logic [7:0] plen_q;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      plen_q <= 8'h00;
    end else begin
      plen_q <= active_q ? ((plen_q == 8'hff) ? plen_q : plen_q + 8'h01) : 8'h00;
    end
  end

  flush_cmd_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cmd_wr && (reg_wdata_in == sfil_pkg::CMD_FIFO_FLUSH || reg_wdata_in == sfil_pkg::CMD_SOFT_RESET)
    |=> fifo_flush_out ##1 !fifo_flush_out)
    else $error("flush command did not pulse flush");

  or_assert_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    contrib |=> active_q)
    else $error("contribution did not assert pin");

  pulse_width_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $fell(active_q) |-> plen_q >= 8'(sfil_pkg::MIN_PULSE_CYC))
    else $error("interrupt pulse shorter than minimum");

  live_release_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    active_q && hold_q == 5'h00 && !contrib |=> !active_q)
    else $error("pin held after conditions cleared");

  drdy_timeout_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    tmr_run_q && tmr_q == CLR_LAST && !drdy_event_in |=> !drdy_pin_q && !tmr_run_q)
    else $error("data ready did not self-clear");

  srst_default_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    srst |=> ctrl_q == sfil_pkg::CTRL_RST ##1 int_oe_out)
    else $error("soft reset did not restore pin defaults");

  full_keep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rd_stat && stat_q.ffull && full_cond && !srst |=> stat_q.ffull)
    else $error("full status cleared while still full");

  late_enable_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !drdy_pin_q && !drdy_event_in |=> !drdy_pin_q)
    else $error("data ready contribution rose without event");

  latch_timer_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    drdy_event_in && ctrl_q.latch && !srst |=> !tmr_run_q)
    else $error("self-clear timer started in latched mode");

  push_pull_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !ctrl_q.pin_drive_type |=> int_oe_out && int_out == ($past(ctrl_q.level) ~^ $past(active_q)))
    else $error("push-pull output level wrong");

endmodule

// >>> src/sfil_pkg.sv
// Shared constants and types of the sensor FIFO interrupt logic.
package sfil_pkg;

  // Register offsets on the serial register interface.
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FIFO_LEN_LO = 8'h11;
  localparam logic [7:0] ADDR_FIFO_LEN_HI = 8'h12;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h13;
  localparam logic [7:0] ADDR_WTM_LO = 8'h15;
  localparam logic [7:0] ADDR_WTM_HI = 8'h16;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1f;

  // Command codes.
  localparam logic [7:0] CMD_FIFO_FLUSH = 8'hb0;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hb6;

  // Interrupt control layout: [6] drdy_en, [4] ffull_en, [3] fwtm_en,
  // [2] latch, [1] level, [0] pin_drive_type.
  typedef struct packed {
    logic rsv7;
    logic drdy_en;
    logic rsv5;
    logic ffull_en;
    logic fwtm_en;
    logic latch;
    logic level;
    logic pin_drive_type;
  } sfil_ctrl_t;
  localparam logic [7:0] CTRL_WR_MASK = 8'h5f;
  localparam logic [7:0] CTRL_RST = 8'h02;

  // Interrupt status layout: [3] drdy, [1] ffull, [0] fwm.
  typedef struct packed {
    logic [3:0] rsv;
    logic drdy;
    logic rsv2;
    logic ffull;
    logic fwm;
  } sfil_stat_t;
  localparam logic [7:0] STAT_RST = 8'h00;

  localparam logic [15:0] FULL_LEVEL = 16'h01f8;
  localparam logic [15:0] WTM_RST = 16'h0000;

  // Over-read frames.
  localparam logic [7:0] HDR_SENSORTIME = 8'ha0;
  localparam logic [7:0] HDR_EMPTY = 8'h80;
  localparam logic [7:0] EMPTY_DATA = 8'h00;
  localparam logic [1:0] TIME_LAST_IDX = 2'h2;

  typedef enum logic [1:0] {
    SO_FIFO = 2'b00,
    SO_TIME = 2'b01,
    SO_EMPTY = 2'b10
  } sfil_ovr_t;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MIN_PULSE_NS = 1000;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRDY_CLR_US = 2500;
  localparam int unsigned DRDY_CLR_CYC_DEF = (DRDY_CLR_US * 1000) / CLK_PERIOD_NS;

endpackage

// >>> src/sfil_overread.sv
// FIFO data port sequencer that appends sensortime and empty frames on over-read.
`timescale 1ns/1ps
module sfil_overread (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic data_rd_in,
  input wire logic burst_end_in,
  input wire logic fifo_empty_in,
  input wire logic [7:0] fifo_byte_in,
  input wire logic time_en_in,
  input wire logic [23:0] sensor_time_in,
  output logic [7:0] byte_out,
  output logic pop_out
);

  sfil_pkg::sfil_ovr_t state_q, state_d;
  logic [1:0] idx_q, idx_d;
  logic phase_q, phase_d;
  logic [23:0] time_q, time_d;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    phase_d = phase_q;
    time_d = time_q;
    byte_out = fifo_byte_in;
    pop_out = 1'b0;
    if (burst_end_in) begin
      state_d = sfil_pkg::SO_FIFO;
      phase_d = 1'b0;
    end else if (data_rd_in) begin
      unique case (state_q)
        sfil_pkg::SO_FIFO: begin
          if (!fifo_empty_in) begin
            pop_out = 1'b1;
          end else if (time_en_in) begin
            // The payload is the counter value at the start of the frame.
            byte_out = sfil_pkg::HDR_SENSORTIME;
            time_d = sensor_time_in;
            idx_d = 2'h0;
            state_d = sfil_pkg::SO_TIME;
          end else begin
            byte_out = sfil_pkg::HDR_EMPTY;
            phase_d = 1'b1;
            state_d = sfil_pkg::SO_EMPTY;
          end
        end
        sfil_pkg::SO_TIME: begin
          byte_out = time_q[idx_q*8 +: 8];
          idx_d = idx_q + 2'h1;
          if (idx_q == sfil_pkg::TIME_LAST_IDX) begin
            phase_d = 1'b0;
            state_d = sfil_pkg::SO_EMPTY;
          end
        end
        sfil_pkg::SO_EMPTY: begin
          // Empty frames repeat until the burst ends.
          byte_out = phase_q ? sfil_pkg::EMPTY_DATA : sfil_pkg::HDR_EMPTY;
          phase_d = ~phase_q;
        end
        default: begin
          state_d = sfil_pkg::SO_FIFO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= sfil_pkg::SO_FIFO;
      idx_q <= 2'h0;
      phase_q <= 1'b0;
      time_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      phase_q <= phase_d;
      time_q <= time_d;
    end
  end

  time_hdr_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_q == sfil_pkg::SO_FIFO && data_rd_in && !burst_end_in && fifo_empty_in && time_en_in)
    |-> byte_out == sfil_pkg::HDR_SENSORTIME ##1 state_q == sfil_pkg::SO_TIME)
    else $error("sensortime header not sent on over-read");

  empty_frame_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_q == sfil_pkg::SO_EMPTY && data_rd_in && !burst_end_in)
    |-> (byte_out == sfil_pkg::HDR_EMPTY || byte_out == sfil_pkg::EMPTY_DATA) && !pop_out)
    else $error("bad empty frame byte");

endmodule

// >>> dv/sfil_host_model.sv
// Host processor model that drives the serial register interface of the interrupt logic.
`timescale 1ns/1ps
module sfil_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic int_in,
  input wire logic int_oe_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic xfer_end_out,
  output logic pin_level_out
);
  // The board pulls the pin up, so a released open-drain pin reads high.
  assign pin_level_out = int_oe_in ? int_in : 1'b1;

  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    xfer_end_out = 1'b0;
  end

  // Released address and data lines show the inverse of their last value, so a stale copy is never mistaken.
  task automatic release_bus();
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~reg_addr_out;
    reg_wdata_out = ~reg_wdata_out;
  endtask

  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk_in);
    reg_addr_out = addr;
    reg_wdata_out = data;
    reg_wr_out = 1'b1;
    @(negedge ref_clk_in);
    release_bus();
  endtask

  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(negedge ref_clk_in);
    reg_addr_out = addr;
    reg_rd_out = 1'b1;
    @(negedge ref_clk_in);
    release_bus();
    @(negedge ref_clk_in);
    data = reg_rdata_in;
  endtask

  task automatic end_xfer();
    @(negedge ref_clk_in);
    xfer_end_out = 1'b1;
    @(negedge ref_clk_in);
    xfer_end_out = 1'b0;
  endtask

  // Both watermark bytes go out in one transaction so the pair takes effect together.
  task automatic set_watermark(input logic [15:0] level);
    write_byte(sfil_pkg::ADDR_WTM_LO, level[7:0]);
    write_byte(sfil_pkg::ADDR_WTM_HI, level[15:8]);
    end_xfer();
  endtask

  task automatic command(input logic [7:0] code);
    write_byte(sfil_pkg::ADDR_CMD, code);
    end_xfer();
  endtask
endmodule

// >>> dv/tb_sensor_fifo_interrupt_logic.sv
// Self-checking testbench of the sensor FIFO interrupt logic.
`timescale 1ns/1ps
module tb_sensor_fifo_interrupt_logic;
  localparam int unsigned CLR_CYC = 40;
  localparam int unsigned TIME_LIMIT = 20000;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] len;
    logic pin;
    logic oe;
  } sfil_row_t;
  localparam sfil_row_t ROWS [0:9] = '{
    '{8'h0a, 16'h0010, 1'b1, 1'b1}, '{8'h0a, 16'h000f, 1'b0, 1'b1},
    '{8'h08, 16'h0010, 1'b0, 1'b1}, '{8'h08, 16'h000f, 1'b1, 1'b1},
    '{8'h09, 16'h0010, 1'b0, 1'b1}, '{8'h0b, 16'h0010, 1'b1, 1'b0},
    '{8'h09, 16'h000f, 1'b1, 1'b0}, '{8'h02, 16'h0010, 1'b0, 1'b1},
    '{8'h12, 16'h01f7, 1'b0, 1'b1}, '{8'h12, 16'h01f8, 1'b1, 1'b1}};
  localparam logic [7:0] OVR_EXP [0:6] = '{8'ha0, 8'h56, 8'h34, 8'h12, 8'h80, 8'h00, 8'h80};

  logic ref_clk_in;
  logic sys_rst_in;
  logic drdy_event, fifo_empty, time_en;
  logic [15:0] fifo_length;
  logic [7:0] fifo_byte;
  logic [23:0] sensor_time;
  logic reg_wr, reg_rd, xfer_end, fifo_pop, fifo_flush, int_pin, int_oe, host_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  int pop_cnt = 0;
  int flush_cnt = 0;

  sfil_top #(.DRDY_CLR_CYC(CLR_CYC)) dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .xfer_end_in(xfer_end),
    .drdy_event_in(drdy_event), .fifo_length_in(fifo_length), .fifo_empty_in(fifo_empty),
    .fifo_byte_in(fifo_byte), .time_en_in(time_en), .sensor_time_in(sensor_time),
    .reg_rdata_out(reg_rdata), .fifo_pop_out(fifo_pop), .fifo_flush_out(fifo_flush),
    .int_out(int_pin), .int_oe_out(int_oe));

  sfil_host_model host (
    .ref_clk_in(ref_clk_in), .reg_rdata_in(reg_rdata), .int_in(int_pin), .int_oe_in(int_oe),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .xfer_end_out(xfer_end), .pin_level_out(host_pin));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (fifo_pop === 1'b1) pop_cnt <= pop_cnt + 1;
    if (fifo_flush === 1'b1) flush_cnt <= flush_cnt + 1;
    if (cycles == TIME_LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic pin_chk(input string name, input logic exp_pin, input logic exp_oe);
    check(name, {14'h0000, host_pin, int_oe}, {14'h0000, exp_pin, exp_oe});
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_byte(addr, d);
    check(name, {8'h00, d}, {8'h00, exp});
  endtask

  task automatic set_ctrl(input logic [7:0] v);
    host.write_byte(sfil_pkg::ADDR_INT_CTRL, v);
  endtask

  task automatic pulse_drdy();
    @(negedge ref_clk_in);
    drdy_event = 1'b1;
    @(negedge ref_clk_in);
    drdy_event = 1'b0;
  endtask

  initial begin
    int n;
    int p0;
    logic [7:0] codes [0:1];
    sys_rst_in = 1'b1;
    drdy_event = 1'b0;
    fifo_length = 16'h0000;
    fifo_empty = 1'b0;
    fifo_byte = 8'h5a;
    time_en = 1'b0;
    sensor_time = 24'h123456;
    codes = '{sfil_pkg::CMD_FIFO_FLUSH, sfil_pkg::CMD_SOFT_RESET};
    wait_cyc(12);
    sys_rst_in = 1'b0;
    pin_chk("pin_rst", 1'b0, 1'b1);
    rd_chk("ctrl_rst", sfil_pkg::ADDR_INT_CTRL, sfil_pkg::CTRL_RST);
    rd_chk("stat_rst", sfil_pkg::ADDR_INT_STATUS, sfil_pkg::STAT_RST);
    rd_chk("unmapped", 8'h14, 8'h00);
    set_ctrl(8'hff);
    rd_chk("ctrl_mask", sfil_pkg::ADDR_INT_CTRL, sfil_pkg::CTRL_WR_MASK);
    host.set_watermark(16'h0010);
    for (int i = 0; i < 10; i++) begin
      set_ctrl(ROWS[i].ctrl);
      fifo_length = ROWS[i].len;
      wait_cyc(30);
      pin_chk("pin_row", ROWS[i].pin, ROWS[i].oe);
    end
    rd_chk("len_lo", sfil_pkg::ADDR_FIFO_LEN_LO, 8'hf8);
    rd_chk("len_hi", sfil_pkg::ADDR_FIFO_LEN_HI, 8'h01);
    rd_chk("wtm_lo", sfil_pkg::ADDR_WTM_LO, 8'h10);
    rd_chk("wtm_hi", sfil_pkg::ADDR_WTM_HI, 8'h00);
    // The new watermark must wait for the end of the transaction that wrote it.
    set_ctrl(8'h0a);
    fifo_length = 16'h0008;
    host.write_byte(sfil_pkg::ADDR_WTM_LO, 8'h08);
    host.write_byte(sfil_pkg::ADDR_WTM_HI, 8'h00);
    wait_cyc(30);
    pin_chk("wtm_pending", 1'b0, 1'b1);
    host.end_xfer();
    wait_cyc(6);
    pin_chk("wtm_taken", 1'b1, 1'b1);
    fifo_byte = 8'h3c;
    rd_chk("fifo_byte", sfil_pkg::ADDR_FIFO_DATA, 8'h3c);
    pin_chk("fifo_read", 1'b1, 1'b1);
    host.set_watermark(16'h0000);
    fifo_length = 16'h0000;
    wait_cyc(30);
    pin_chk("wtm_zero", 1'b0, 1'b1);
    rd_chk("stat_zero", sfil_pkg::ADDR_INT_STATUS, 8'h00);
    host.set_watermark(16'h0010);
    set_ctrl(8'h02);
    fifo_length = 16'h0010;
    wait_cyc(4);
    rd_chk("stat_masked", sfil_pkg::ADDR_INT_STATUS, 8'h01);
    fifo_length = 16'h0000;
    set_ctrl(8'h42);
    pulse_drdy();
    wait_cyc(4);
    pin_chk("drdy_on", 1'b1, 1'b1);
    wait_cyc(CLR_CYC + 10);
    pin_chk("drdy_self_clear", 1'b0, 1'b1);
    rd_chk("drdy_stat", sfil_pkg::ADDR_INT_STATUS, 8'h08);
    rd_chk("drdy_cleared", sfil_pkg::ADDR_INT_STATUS, 8'h00);
    // A read right after the event ends the contribution early; the pulse must still be long.
    n = 0;
    pulse_drdy();
    fork
      repeat (40) begin
        @(negedge ref_clk_in);
        if (host_pin === 1'b1) n++;
      end
      rd_chk("drdy_read", sfil_pkg::ADDR_INT_STATUS, 8'h08);
    join
    check("pulse_len", 16'((n >= sfil_pkg::MIN_PULSE_CYC) && (n < 40)), 16'h0001);
    set_ctrl(8'h02);
    pulse_drdy();
    wait_cyc(4);
    set_ctrl(8'h42);
    wait_cyc(10);
    pin_chk("drdy_late_en", 1'b0, 1'b1);
    rd_chk("drdy_late_stat", sfil_pkg::ADDR_INT_STATUS, 8'h08);
    pulse_drdy();
    wait_cyc(4);
    pin_chk("drdy_next", 1'b1, 1'b1);
    rd_chk("drdy_next_stat", sfil_pkg::ADDR_INT_STATUS, 8'h08);
    wait_cyc(30);
    set_ctrl(8'h46);
    pulse_drdy();
    wait_cyc(4);
    set_ctrl(8'h42);
    wait_cyc(CLR_CYC + 20);
    pin_chk("drdy_no_timer", 1'b1, 1'b1);
    rd_chk("drdy_latched", sfil_pkg::ADDR_INT_STATUS, 8'h08);
    wait_cyc(30);
    pin_chk("drdy_read_off", 1'b0, 1'b1);
    set_ctrl(8'h0e);
    fifo_length = 16'h0010;
    wait_cyc(10);
    fifo_length = 16'h0008;
    wait_cyc(30);
    pin_chk("fwm_latched", 1'b1, 1'b1);
    rd_chk("fwm_stat", sfil_pkg::ADDR_INT_STATUS, 8'h01);
    wait_cyc(30);
    pin_chk("fwm_released", 1'b0, 1'b1);
    rd_chk("fwm_gone", sfil_pkg::ADDR_INT_STATUS, 8'h00);
    host.set_watermark(16'h0000);
    set_ctrl(8'h16);
    fifo_length = sfil_pkg::FULL_LEVEL;
    wait_cyc(10);
    pin_chk("full_pin", 1'b1, 1'b1);
    rd_chk("full_stat", sfil_pkg::ADDR_INT_STATUS, 8'h02);
    rd_chk("full_kept", sfil_pkg::ADDR_INT_STATUS, 8'h02);
    fifo_length = sfil_pkg::FULL_LEVEL - 16'h0001;
    rd_chk("full_last", sfil_pkg::ADDR_INT_STATUS, 8'h02);
    rd_chk("full_clear", sfil_pkg::ADDR_INT_STATUS, 8'h00);
    wait_cyc(30);
    pin_chk("full_off", 1'b0, 1'b1);
    set_ctrl(8'h02);
    p0 = pop_cnt;
    fifo_byte = 8'h5a;
    rd_chk("stored", sfil_pkg::ADDR_FIFO_DATA, 8'h5a);
    check("pop_one", 16'(pop_cnt - p0), 16'h0001);
    fifo_empty = 1'b1;
    time_en = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk("overread", sfil_pkg::ADDR_FIFO_DATA, OVR_EXP[i]);
    end
    host.end_xfer();
    time_en = 1'b0;
    rd_chk("empty_hdr", sfil_pkg::ADDR_FIFO_DATA, sfil_pkg::HDR_EMPTY);
    rd_chk("empty_data", sfil_pkg::ADDR_FIFO_DATA, sfil_pkg::EMPTY_DATA);
    host.end_xfer();
    check("no_pop", 16'(pop_cnt - p0), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      set_ctrl(8'h0b);
      p0 = flush_cnt;
      host.command(codes[i]);
      wait_cyc(4);
      check("flush", 16'(flush_cnt - p0), 16'h0001);
      rd_chk("ctrl_after", sfil_pkg::ADDR_INT_CTRL, (i == 1) ? sfil_pkg::CTRL_RST : 8'h0b);
    end
    pin_chk("pin_soft_rst", 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
